// ### hw/tpcu_pkg.sv
// package: constants, types and helpers of the timer pwm channel unit
// Overview of operation
// - edge-aligned pwm when center select clear and mode pair is 1:0
// - edge pwm period is modulus plus one ticks, width set by channel value
// - edge pwm sets channel flag on counter equal value; interrupt if enabled
// - edge pwm with edge/level 0:0 flags on match, leaves output alone
// - edge pwm 1:0 drives high at reload to zero, low on match
// - edge pwm X:1 drives low at reload to zero, high on match
// - edge pwm channel value zero gives constant 0% duty
// - edge pwm value above modulus gives 100% duty and never flags
// - center-aligned pwm when center select set and mode pair is 1:0
// - center pwm flags on every match, counting down and counting up
// - center pwm 1:0 drives high on down match, low on up match
// - center pwm X:1 drives low on down match, high on up match
// - center pwm with edge/level 0:0 flags on match, leaves output alone
// - center pwm zero value 0% duty; above modulus 100%, flag at turn
// - modulus loads at once when stopped, else at wrap or at turn
// - outside input capture, channel value loads at once when stopped, else per mode event
// - counter trigger rises with overflow flag, holds until next increment
// - pre-trigger on flag set, trigger next increment, both drop after
// - reset clears counter, prescaler, flags; channels input capture, idle
// - interrupt requests are flag and enable, overflow and per channel
// - up counting flags overflow on modulus to zero wrap
// - center select counts up then down; overflow on modulus to minus one
package tpcu_pkg;

	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_COUNT     = 8'h08;
	localparam logic [7:0] OFS_MODULUS   = 8'h0C;
	localparam logic [7:0] OFS_CHAN_BASE = 8'h10;
	localparam logic [7:0] CHAN_STRIDE   = 8'h08;
	localparam logic [7:0] OFS_CSC       = 8'h00;
	localparam logic [7:0] OFS_VALUE     = 8'h04;
	localparam int         CTRL_W        = 7;
	localparam int         CSC_CFG_W     = 5;
	localparam int         CSC_FLAG      = 5;
	localparam int         STS_OVF       = 0;
	localparam int         STS_CHAN      = 1;
	localparam logic [1:0] CLK_OFF       = 2'h0;
	localparam logic [1:0] ELS_NONE      = 2'h0;

	typedef struct packed {
		logic [2:0] prescale;
		logic       overflow_irq_enable;
		logic       center_align_select;
		logic [1:0] counter_clock_mode;
	} tpcu_ctrl_s;

	typedef struct packed {
		logic chan_mode_sel_hi;
		logic chan_mode_sel_lo;
		logic chan_edge_level_hi;
		logic chan_edge_level_lo;
		logic chan_irq_enable;
	} tpcu_chcfg_s;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} tpcu_bus_s;

	typedef enum logic [4:0] {
		MODE_ICAP = 5'h01,
		MODE_OCMP = 5'h02,
		MODE_EDGE_ALIGNED_PWM = 5'h04,
		MODE_CENTER_ALIGNED_PWM = 5'h08,
		MODE_NONE = 5'h10
	} tpcu_mode_e;

	function automatic tpcu_mode_e tpcu_mode(input logic center, input tpcu_chcfg_s c);
		if (center)
			return (c.chan_mode_sel_hi && !c.chan_mode_sel_lo) ? MODE_CENTER_ALIGNED_PWM : MODE_NONE;
		if (c.chan_mode_sel_lo)
			return MODE_OCMP;
		return c.chan_mode_sel_hi ? MODE_EDGE_ALIGNED_PWM : MODE_ICAP;
	endfunction

	function automatic logic [7:0] tpcu_chan_addr(input int i, input logic [7:0] ofs);
		return 8'(int'(OFS_CHAN_BASE) + int'(CHAN_STRIDE) * i + int'(ofs));
	endfunction

endpackage

// ### hw/tpcu_prescaler.sv
// prescaler: divides the clock into one-cycle counter tick pulses
`timescale 1ns/100ps
module tpcu_prescaler (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	// control
	input  wire logic       en_i,
	input  wire logic       clr_i,
	input  wire logic [2:0] ps_i,
	// tick
	output logic            tick_o
);
	typedef struct packed {
		logic [6:0] cnt;
	} tpcu_psc_s;

	tpcu_psc_s  s_q;
	tpcu_psc_s  s_d;
	logic [6:0] lim;

	always_comb
	begin
		s_d = s_q;
		lim = 7'((8'h01 << ps_i) - 8'h01);
		tick_o = en_i && !clr_i && (s_q.cnt >= lim);
		if (clr_i)
			s_d.cnt = 7'h00;
		else if (tick_o)
			s_d.cnt = 7'h00;
		else if (en_i)
			s_d.cnt = s_q.cnt + 7'h01;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule

// ### hw/tpcu_channel.sv
// channel: match detection, flag event and output level of one channel
`timescale 1ns/100ps
module tpcu_channel
	import tpcu_pkg::*;
(
	// counter step
	input  wire logic        tick_i,
	input  wire logic        wrap_i,
	input  wire logic        turn_i,
	input  wire logic        up_i,
	input  wire logic [15:0] cnt_i,
	input  wire logic [15:0] mod_i,
	// channel setup
	input  wire tpcu_mode_e  mode_i,
	input  wire tpcu_chcfg_s cfg_i,
	input  wire logic [15:0] cv_i,
	input  wire logic        out_i,
	// results
	output logic             set_o,
	output logic             out_o,
	output logic             oe_o
);
	logic       match;
	logic       over;
	logic [1:0] els;

	always_comb
	begin
		match = tick_i && (cnt_i == cv_i);
		over = cv_i > mod_i;
		els = {cfg_i.chan_edge_level_hi, cfg_i.chan_edge_level_lo};
		set_o = 1'b0;
		out_o = out_i;
		oe_o = (els != ELS_NONE) && (mode_i != MODE_ICAP) && (mode_i != MODE_NONE);
		unique case (mode_i)
			MODE_EDGE_ALIGNED_PWM:
			begin
				set_o = match;
				if (oe_o)
				begin
					// match after reload so a zero value stays at the match level (low for 1:0, high for X:1) for the whole period
					if (wrap_i)
						out_o = !cfg_i.chan_edge_level_lo;
					if (match)
						out_o = cfg_i.chan_edge_level_lo;
				end
			end
			MODE_CENTER_ALIGNED_PWM:
			begin
				set_o = match || (turn_i && over);
				if (oe_o && match)
					out_o = up_i ? cfg_i.chan_edge_level_lo : !cfg_i.chan_edge_level_lo;
				else if (oe_o && turn_i && over)
					out_o = !cfg_i.chan_edge_level_lo;
			end
			MODE_OCMP:
			begin
				set_o = match;
				if (match && els == 2'h1)
					out_o = !out_i;
				else if (match)
					out_o = cfg_i.chan_edge_level_lo;
			end
			MODE_ICAP, MODE_NONE:
			begin
				set_o = 1'b0;
			end
		endcase
	end
endmodule

// ### hw/tpcu_top.sv
// top: registers, counter, buffered loads, flags, triggers and channels
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/100ps
module tpcu_top
	import tpcu_pkg::*;
#(
	parameter int NCH = 2
) (
	// clock and reset
	input  wire logic               mclk_i,
	input  wire logic               rst_n_i,
	// register port
	input  wire tpcu_pkg::tpcu_bus_s bus_i,
	output logic [31:0]             rdata_o,
	// channel pins
	output logic [NCH-1:0]          chan_out_o,
	output logic [NCH-1:0]          chan_oe_o,
	// interrupt requests
	output logic                    ovf_irq_o,
	output logic [NCH-1:0]          chan_irq_o,
	// triggers
	output logic                    cnt_trig_o,
	output logic [NCH-1:0]          chan_pretrig_o,
	output logic [NCH-1:0]          chan_trig_o
);
	typedef struct packed {
		tpcu_ctrl_s            ctrl;
		logic [15:0]           cnt;
		logic                  down;
		logic [15:0]           modv;
		logic [15:0]           mod_buf;
		logic                  mod_pend;
		logic                  overflow_flag;
		logic                  ovf_trig;
		logic                  ovf_irq;
		logic [31:0]           rdata;
		tpcu_chcfg_s [NCH-1:0] cfg;
		logic [NCH-1:0][15:0]  cv;
		logic [NCH-1:0][15:0]  cv_buf;
		logic [NCH-1:0]        cv_pend;
		logic [NCH-1:0]        chan_flag;
		logic [NCH-1:0]        pre;
		logic [NCH-1:0]        trg;
		logic [NCH-1:0]        out;
		logic [NCH-1:0]        oe;
		logic [NCH-1:0]        irq;
	} tpcu_state_s;

	tpcu_state_s    s_q;
	tpcu_state_s    s_d;
	logic           run;
	logic           tick;
	logic           cnt_wr;
	logic           wrap;
	logic           turn;
	logic           ch_up;
	logic [15:0]    cnt_nxt;
	logic           down_nxt;
	tpcu_mode_e     mode [NCH];
	logic [NCH-1:0] ch_set;
	logic [NCH-1:0] ch_out;
	logic [NCH-1:0] ch_oe;

	assign run = s_q.ctrl.counter_clock_mode != CLK_OFF;
	assign cnt_wr = bus_i.wr && (bus_i.addr == OFS_COUNT);

	tpcu_prescaler u_psc (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.en_i    (run),
		.clr_i   (cnt_wr),
		.ps_i    (s_q.ctrl.prescale),
		.tick_o  (tick)
	);

	// counter step, kept apart so the channels can feed the state update
	always_comb
	begin
		cnt_nxt = s_q.cnt;
		down_nxt = s_q.down;
		wrap = 1'b0;
		turn = 1'b0;
		if (tick && !s_q.ctrl.center_align_select)
		begin
			if (s_q.cnt == s_q.modv)
			begin
				cnt_nxt = 16'h0000;
				wrap = 1'b1;
			end
			else
				cnt_nxt = s_q.cnt + 16'h0001;
		end
		else if (tick && !s_q.down)
		begin
			// beyond modulus after a reload also turns, to avoid a long climb
			if (s_q.cnt >= s_q.modv)
			begin
				cnt_nxt = s_q.modv - 16'h0001;
				down_nxt = 1'b1;
				turn = 1'b1;
			end
			else
				cnt_nxt = s_q.cnt + 16'h0001;
		end
		else if (tick)
		begin
			if (s_q.cnt == 16'h0000)
			begin
				cnt_nxt = 16'h0001;
				down_nxt = 1'b0;
			end
			else
				cnt_nxt = s_q.cnt - 16'h0001;
		end
		// zero counts as up so a zero value never opens a pulse
		ch_up = !(down_nxt && cnt_nxt != 16'h0000);
	end

	for (genvar g = 0; g < NCH; g++)
	begin : g_ch
		assign mode[g] = tpcu_mode(s_q.ctrl.center_align_select, s_q.cfg[g]);

		tpcu_channel u_ch (
			.tick_i (tick),
			.wrap_i (wrap),
			.turn_i (turn),
			.up_i   (ch_up),
			.cnt_i  (cnt_nxt),
			.mod_i  (s_q.modv),
			.mode_i (mode[g]),
			.cfg_i  (s_q.cfg[g]),
			.cv_i   (s_q.cv[g]),
			.out_i  (s_q.out[g]),
			.set_o  (ch_set[g]),
			.out_o  (ch_out[g]),
			.oe_o   (ch_oe[g])
		);
	end

	always_comb
	begin
		logic        sts_wr;
		logic        csc_wr;
		logic        val_wr;
		logic        clr;
		logic        load;
		logic [31:0] rv;
		sts_wr = bus_i.wr && (bus_i.addr == OFS_STATUS);
		csc_wr = 1'b0;
		val_wr = 1'b0;
		clr = 1'b0;
		load = 1'b0;
		rv = 32'h0000_0000;
		s_d = s_q;

		if (bus_i.wr && bus_i.addr == OFS_CTRL)
			s_d.ctrl = tpcu_ctrl_s'(bus_i.wdata[CTRL_W-1:0]);

		// a count write restarts the counter and the prescaler
		s_d.cnt = cnt_wr ? 16'h0000 : cnt_nxt;
		s_d.down = cnt_wr ? 1'b0 : down_nxt;

		// set wins over a write-one clear landing in the same cycle
		clr = sts_wr && bus_i.wdata[STS_OVF];
		s_d.overflow_flag = (s_q.overflow_flag && !clr) || wrap || turn;
		s_d.ovf_irq = s_d.overflow_flag && s_d.ctrl.overflow_irq_enable;

		if (wrap || turn)
			s_d.ovf_trig = 1'b1;
		else if (tick)
			s_d.ovf_trig = 1'b0;

		load = s_q.ctrl.center_align_select ? turn : wrap;
		if (s_q.mod_pend && (!run || load))
		begin
			s_d.modv = s_q.mod_buf;
			s_d.mod_pend = 1'b0;
		end
		if (bus_i.wr && bus_i.addr == OFS_MODULUS)
		begin
			s_d.mod_buf = bus_i.wdata[15:0];
			if (run)
				s_d.mod_pend = 1'b1;
			else
				s_d.modv = bus_i.wdata[15:0];
		end

		for (int i = 0; i < NCH; i++)
		begin
			csc_wr = bus_i.wr && (bus_i.addr == tpcu_chan_addr(i, OFS_CSC));
			val_wr = bus_i.wr && (bus_i.addr == tpcu_chan_addr(i, OFS_VALUE));
			load = ((mode[i] == MODE_OCMP) && tick) || ((mode[i] == MODE_EDGE_ALIGNED_PWM) && wrap)
				|| ((mode[i] == MODE_CENTER_ALIGNED_PWM) && turn);
			if (s_q.cv_pend[i] && (!run || load))
			begin
				s_d.cv[i] = s_q.cv_buf[i];
				s_d.cv_pend[i] = 1'b0;
			end
			// value writes are dropped while the channel captures
			if (val_wr && mode[i] != MODE_ICAP)
			begin
				s_d.cv_buf[i] = bus_i.wdata[15:0];
				if (run)
					s_d.cv_pend[i] = 1'b1;
				else
					s_d.cv[i] = bus_i.wdata[15:0];
			end
			if (csc_wr)
				s_d.cfg[i] = tpcu_chcfg_s'(bus_i.wdata[CSC_CFG_W-1:0]);

			clr = (csc_wr && bus_i.wdata[CSC_FLAG]) || (sts_wr && bus_i.wdata[STS_CHAN+i]);
			s_d.chan_flag[i] = (s_q.chan_flag[i] && !clr) || ch_set[i];
			s_d.irq[i] = s_d.chan_flag[i] && s_d.cfg[i].chan_irq_enable;

			if (ch_set[i])
			begin
				s_d.pre[i] = 1'b1;
				s_d.trg[i] = 1'b0;
			end
			else if (tick && s_q.trg[i])
			begin
				s_d.pre[i] = 1'b0;
				s_d.trg[i] = 1'b0;
			end
			else if (tick && s_q.pre[i])
				s_d.trg[i] = 1'b1;

			s_d.out[i] = ch_out[i];
			s_d.oe[i] = ch_oe[i];

			if (bus_i.addr == tpcu_chan_addr(i, OFS_CSC))
				rv = {26'h0, s_q.chan_flag[i], s_q.cfg[i]};
			else if (bus_i.addr == tpcu_chan_addr(i, OFS_VALUE))
				rv = {16'h0000, s_q.cv_buf[i]};
		end

		unique case (bus_i.addr)
			OFS_CTRL:    rv = {25'h0, s_q.ctrl};
			OFS_STATUS:  rv = 32'({s_q.chan_flag, s_q.overflow_flag});
			OFS_COUNT:   rv = {16'h0000, s_q.cnt};
			OFS_MODULUS: rv = {16'h0000, s_q.mod_buf};
			default:     rv = rv;
		endcase
		s_d.rdata = bus_i.rd ? rv : 32'h0000_0000;
	end

	// reset leaves everything stopped, flags clear, channels capturing
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign rdata_o = s_q.rdata;
	assign chan_out_o = s_q.out;
	assign chan_oe_o = s_q.oe;
	assign ovf_irq_o = s_q.ovf_irq;
	assign chan_irq_o = s_q.irq;
	assign cnt_trig_o = s_q.ovf_trig;
	assign chan_pretrig_o = s_q.pre;
	assign chan_trig_o = s_q.trg;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic epwm0;
	logic cpwm0;
	assign epwm0 = mode[0] == MODE_EDGE_ALIGNED_PWM;
	assign cpwm0 = mode[0] == MODE_CENTER_ALIGNED_PWM;

	AST_EDGE_ALIGNED_PWM_FLAG: assert property (epwm0 && tick && cnt_nxt == s_q.cv[0] |=> s_q.chan_flag[0])
		else $error("edge pwm match did not set the channel flag");
	AST_EDGE_ALIGNED_PWM_OVER: assert property (epwm0 && !s_q.chan_flag[0] && s_q.cv[0] > s_q.modv && !s_q.cv_pend[0]
		&& !s_q.mod_pend && s_q.cnt <= s_q.modv |=> !s_q.chan_flag[0])
		else $error("edge pwm flag set with value above modulus");
	AST_EDGE_ALIGNED_PWM_HI: assert property (epwm0 && s_q.cfg[0].chan_edge_level_hi && !s_q.cfg[0].chan_edge_level_lo
		&& wrap && s_q.cv[0] != 16'h0000 |=> chan_out_o[0] && chan_oe_o[0])
		else $error("edge pwm output not high after reload");
	AST_EDGE_ALIGNED_PWM_LO: assert property (epwm0 && s_q.cfg[0].chan_edge_level_lo && wrap && s_q.cv[0] != 16'h0000
		|=> !chan_out_o[0])
		else $error("edge pwm inverted output not low after reload");
	AST_ZERO_DUTY: assert property (epwm0 && s_q.cfg[0].chan_edge_level_hi && !s_q.cfg[0].chan_edge_level_lo
		&& s_q.cv[0] == 16'h0000 && wrap |=> !chan_out_o[0] && s_q.chan_flag[0])
		else $error("zero value edge pwm went high");
	AST_CENTER_ALIGNED_PWM_DOWN: assert property (cpwm0 && s_q.cfg[0].chan_edge_level_hi && !s_q.cfg[0].chan_edge_level_lo
		&& tick && cnt_nxt == s_q.cv[0] && !ch_up |=> chan_out_o[0])
		else $error("center pwm down match did not drive high");
	AST_CNT_TRIG: assert property ($rose(s_q.overflow_flag) |-> cnt_trig_o)
		else $error("counter trigger missing with overflow flag");
	AST_TRIG_HOLD: assert property (cnt_trig_o && !tick && !wrap && !turn |=> cnt_trig_o)
		else $error("counter trigger dropped before next increment");
	AST_PRE_TRIG: assert property (chan_pretrig_o[0] && !chan_trig_o[0] && tick && !ch_set[0]
		|=> chan_trig_o[0] && chan_pretrig_o[0])
		else $error("channel trigger did not follow the pre-trigger");
	AST_IRQ: assert property (chan_irq_o[0] == (s_q.chan_flag[0] && s_q.cfg[0].chan_irq_enable)
		&& ovf_irq_o == (s_q.overflow_flag && s_q.ctrl.overflow_irq_enable))
		else $error("interrupt request differs from flag and enable");
	AST_MOD_NOW: assert property (bus_i.wr && bus_i.addr == OFS_MODULUS && !run
		|=> s_q.modv == $past(bus_i.wdata[15:0]))
		else $error("modulus not loaded at once with counter stopped");

	COV_EDGE_ALIGNED_PWM_WRAP: cover property (epwm0 && wrap ##1 chan_out_o[0]);
	COV_CENTER_ALIGNED_PWM_TURN: cover property (cpwm0 && turn);
	COV_TRIG_SEQ: cover property (ch_set[0] ##[1:300] chan_trig_o[0]);
endmodule

// ### tb/tpcu_pin_model.sv
// partner: channel pins with pull-down and a peripheral counting trigger events
`timescale 1ns/100ps
module tpcu_pin_model #(
	parameter int NCH = 2
) (
	// clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  rst_n_i,
	// from the timer
	input  wire logic [NCH-1:0]        chan_out_i,
	input  wire logic [NCH-1:0]        chan_oe_i,
	input  wire logic                  cnt_trig_i,
	input  wire logic [NCH-1:0]        chan_pretrig_i,
	input  wire logic [NCH-1:0]        chan_trig_i,
	// observed
	output logic [NCH-1:0]             pin_o,
	output logic [15:0]                cnt_ev_o,
	output logic [NCH-1:0][15:0]       trig_ev_o,
	output logic [NCH-1:0][15:0]       pre_ev_o
);
	logic                   cnt_q;
	logic [NCH-1:0]         trig_q;
	logic [NCH-1:0]         pre_q;

	// released pin falls to the pull-down, so a stale level never reads as driven
	assign pin_o = chan_out_i & chan_oe_i;

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q <= 1'b0;
			trig_q <= '0;
			pre_q <= '0;
			cnt_ev_o <= '0;
			trig_ev_o <= '0;
			pre_ev_o <= '0;
		end
		else
		begin
			cnt_q <= cnt_trig_i;
			trig_q <= chan_trig_i;
			pre_q <= chan_pretrig_i;
			cnt_ev_o <= cnt_ev_o + 16'(cnt_trig_i & !cnt_q);
			for (int i = 0; i < NCH; i++)
			begin
				trig_ev_o[i] <= trig_ev_o[i] + 16'(chan_trig_i[i] & !trig_q[i]);
				pre_ev_o[i] <= pre_ev_o[i] + 16'(chan_pretrig_i[i] & !pre_q[i]);
			end
		end
	end
endmodule

// ### tb/tb.sv
// testbench: pwm channel unit against the pin and trigger model
`timescale 1ns/100ps
module tb;
	import tpcu_pkg::*;
	localparam int NCH = 2;
	logic                  mclk_i = 1'b0;
	logic                  rst_n_i = 1'b0;
	tpcu_bus_s             bus = '0;
	logic [31:0]           rdata_o;
	logic [NCH-1:0]        chan_out_o, chan_oe_o, chan_irq_o, chan_pretrig_o, chan_trig_o, pin;
	logic                  ovf_irq_o, cnt_trig_o;
	logic                  rd_seen = 1'b0;
	logic [15:0]           cnt_ev;
	logic [NCH-1:0][15:0]  trig_ev, pre_ev;
	logic [31:0]           exp_q[$];
	int                    mismatches = 0;
	int                    samples_checked = 0;

	always #20 mclk_i = ~mclk_i;

	tpcu_top #(.NCH(NCH)) u_tpcu_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata_o),
		.chan_out_o(chan_out_o), .chan_oe_o(chan_oe_o), .ovf_irq_o(ovf_irq_o), .chan_irq_o(chan_irq_o),
		.cnt_trig_o(cnt_trig_o), .chan_pretrig_o(chan_pretrig_o), .chan_trig_o(chan_trig_o));

	tpcu_pin_model #(.NCH(NCH)) u_tpcu_pin_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .chan_out_i(chan_out_o),
		.chan_oe_i(chan_oe_o), .cnt_trig_i(cnt_trig_o), .chan_pretrig_i(chan_pretrig_o),
		.chan_trig_i(chan_trig_o), .pin_o(pin), .cnt_ev_o(cnt_ev), .trig_ev_o(trig_ev), .pre_ev_o(pre_ev));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_i);
		bus <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge mclk_i);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk_i);
		bus <= '0;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge mclk_i)
	begin
		rd_seen <= bus.rd;
		if (rd_seen && exp_q.size() > 0)
			check(rdata_o, exp_q.pop_front());
	end

	function automatic int hi_exp(input logic c, input int m, input int v, input int p);
		if (v > m)
			return c ? p * 2 * m : p * (m + 1);
		return c ? p * 2 * v : p * v;
	endfunction

	function automatic int trig_exp(input logic c, input int m, input int v, input int p);
		if (v > m)
			return c ? p : 0;
		return (c && v != 0) ? 2 * p : p;
	endfunction

	// ch0 always els 1:0, ch1 els 0:1 or 0:0; window spans whole periods so phase drops out
	// prescale stretches every tick to 2^ps clocks, so levels scale and event counts stay
	task automatic run_case(input logic c, input int m, input int v0, input int v1, input logic [7:0] csc1,
		input logic [2:0] ps);
		int          p, len, w, sc;
		logic        m0;
		logic [31:0] hi0, hi1;
		logic [15:0] e0, t0, t1, r0;
		p = c ? 2 : 4;
		sc = 1 << ps;
		len = c ? 2 * m : m + 1;
		w = p * len * sc;
		m0 = trig_exp(c, m, v0, p) != 0;
		wr(8'h10, 32'h15);
		wr(8'h18, {24'h0, csc1});
		wr(8'h0C, 32'(m));
		wr(8'h14, 32'(v0));
		wr(8'h1C, 32'(v1));
		rd(8'h0C, 32'(m));
		rd(8'h14, 32'(v0));
		wr(8'h08, 32'h0);
		wr(8'h00, {25'h0, ps, 1'b1, c, 2'h1});
		repeat ((2 * len + 4) * sc) @(posedge mclk_i);
		hi0 = 0;
		hi1 = 0;
		e0 = cnt_ev;
		t0 = trig_ev[0];
		t1 = trig_ev[1];
		r0 = pre_ev[0];
		repeat (w)
		begin
			@(posedge mclk_i);
			hi0 += pin[0];
			hi1 += pin[1];
		end
		check(hi0, sc * hi_exp(c, m, v0, p));
		check(hi1, csc1 == 8'h11 ? 0 : w - sc * hi_exp(c, m, v1, p));
		check(chan_oe_o, {csc1 != 8'h11, 1'b1});
		check(32'(cnt_ev - e0), p);
		check(32'(trig_ev[0] - t0), trig_exp(c, m, v0, p));
		check(32'(trig_ev[1] - t1), trig_exp(c, m, v1, p));
		check(32'(pre_ev[0] - r0), trig_exp(c, m, v0, p));
		wr(8'h00, {28'h0, 1'b1, c, 2'h0});
		repeat (3) @(posedge mclk_i);
		check(ovf_irq_o, 1);
		check(chan_irq_o, {1'b1, m0});
		rd(8'h04, {29'h0, 1'b1, m0, 1'b1});
		wr(8'h04, 32'h7);
		rd(8'h04, 32'h0);
		check({ovf_irq_o, chan_irq_o}, 0);
		$display("test center=%0d mod=%0d v0=%0d v1=%0d done", c, m, v0, v1);
	endtask

	initial
	begin
		int m;
		void'($urandom(32'hA0B1));
		repeat (4) @(posedge mclk_i);
		check({chan_out_o, chan_oe_o, ovf_irq_o, chan_irq_o, cnt_trig_o, chan_trig_o}, 0);
		rst_n_i <= 1'b1;
		wr(8'h14, 32'h5);
		for (int a = 0; a < 8; a++)
			rd(8'(4 * a), 32'h0);
		wr(8'hFC, 32'hFFFF);
		rd(8'hFC, 32'h0);
		$display("test reset values done");
		for (int i = 0; i < 8; i++)
		begin
			m = 4 + $urandom % 6;
			// values from 2 keep the two center matches apart, so the pre-trigger drops between them
			run_case(i[0], m, 2 + $urandom % (m - 3), 2 + $urandom % (m - 3), i[1] ? 8'h11 : 8'h13,
				3'($urandom % 3));
		end
		run_case(0, 6, 0, 2, 8'h13, 3'h1);
		run_case(0, 6, 'hFFFF, 2, 8'h11, 3'h0);
		run_case(1, 5, 0, 2, 8'h13, 3'h0);
		run_case(1, 5, 6, 3, 8'h11, 3'h1);
		wr(8'h00, 32'h9);
		repeat (5) @(posedge mclk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		check({chan_out_o, chan_oe_o, ovf_irq_o, chan_irq_o, cnt_trig_o, chan_trig_o}, 0);
		rst_n_i <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h0C, 32'h0);
		repeat (3) @(posedge mclk_i);
		$display("test mid-run reset done");
		tally_and_finish();
	end

	initial
	begin
		repeat (10000) @(posedge mclk_i);
		mismatches++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule
